// [rtl/orad_top.sv]
// output routing, interface selection, alarms and error diagnostics
//
// Summary of operation
// - one-wire only during twenty millisecond start window and command mode
// - host request in window holds command mode
// - window expiry selects I2C or SPI, main pin
// - stored setting enables or skips start window
// - SPI: aux b select, aux a out, SDA in
// - SPI mode never drives threshold flag b
// - SPI aux a: data in command or when unused, flag or pulse otherwise
// - SPI command traffic interrupts main pulse output
// - I2C configurations map aux pins per table
// - three 15-bit results, each routable independently
// - DAC to main pin, pulse to either pin
// - DAC receives 11-bit code from result
// - pulse duty from value, 12-bit, 9-bit fastest
// - two programmable alarm channels with window mode
// - alarms evaluate bridge result only
// - signature mismatch at initialization flags error
// - parity error sets controller flag, forces diagnostics
// - diagnostic mode drives analog extreme, error code
// - watchdog flags stalled controller or measurement loop
// - input range comparators flag broken wire
// - memory and register corruption is an error
// - configuration word selects regulator setpoint, four steps
`timescale 1ns/1ps
module orad_top
	import orad_pkg::*;
#(
	parameter int unsigned START_CYC = orad_pkg::START_WINDOW_CYC,
	parameter int unsigned WDG_LIMIT = orad_pkg::WDG_LIMIT_DEF
)
(
	// clock and reset
	input  wire logic                         i_clk,
	input  wire logic                         i_reset_n,
	// stored configuration
	input  wire logic                         i_start_window_en,
	input  wire logic                         i_spi_select,
	input  wire logic [orad_pkg::CFG_W-1:0]   i_pin_config,
	input  wire logic [1:0]                   i_dac_source,
	input  wire logic [1:0]                   i_main_pulse_source,
	input  wire logic [1:0]                   i_aux_pulse_source,
	input  wire logic [3:0]                   i_pulse_resolution,
	input  wire logic [orad_pkg::DIV_W-1:0]   i_pulse_divider,
	input  wire logic [1:0]                   i_regulator_setting,
	// alarm settings, channel a then b
	input  wire logic [orad_pkg::RES_W-1:0]   i_alarm_threshold [2],
	input  wire logic [orad_pkg::RES_W-1:0]   i_alarm_hysteresis [2],
	input  wire logic [1:0]                   i_alarm_invert,
	input  wire logic [1:0]                   i_alarm_window,
	input  wire logic [orad_pkg::DLY_W-1:0]   i_alarm_on_delay [2],
	input  wire logic [orad_pkg::DLY_W-1:0]   i_alarm_off_delay [2],
	// results
	input  wire logic [orad_pkg::RES_W-1:0]   i_result_bridge,
	input  wire logic [orad_pkg::RES_W-1:0]   i_result_temp1,
	input  wire logic [orad_pkg::RES_W-1:0]   i_result_temp2,
	input  wire logic                         i_result_valid,
	// serial interface events
	input  wire logic                         i_one_wire_request,
	input  wire logic                         i_mode_set_command,
	input  wire logic                         i_spi_command_active,
	input  wire logic                         i_spi_sdo,
	input  wire logic                         i_spi_sdo_en,
	// supervision inputs
	input  wire logic                         i_signature_check_done,
	input  wire logic                         i_signature_match,
	input  wire logic                         i_parity_error,
	input  wire logic                         i_memory_error,
	input  wire logic                         i_controller_alive,
	input  wire logic                         i_loop_progress,
	input  wire logic                         i_inp_range_low,
	input  wire logic                         i_inp_range_high,
	input  wire logic                         i_error_high_level,
	// interface state
	output logic                              o_start_window,
	output logic                              o_command_mode,
	output logic                              o_one_wire_active,
	output logic                              o_i2c_active,
	output logic                              o_spi_active,
	// main pin
	output logic                              o_main_pin_driver,
	output logic                              o_main_pin_oe,
	output logic                              o_main_analog_en,
	output logic [orad_pkg::DAC_W-1:0]        o_dac_code,
	// aux pins
	output logic                              o_aux_pin_a,
	output logic                              o_aux_pin_a_oe,
	output logic                              o_aux_pin_b,
	output logic                              o_aux_pin_b_oe,
	output logic                              o_aux_pin_b_select_in,
	output logic                              o_sda_data_in,
	// alarms
	output logic                              o_threshold_flag_a,
	output logic                              o_threshold_flag_b,
	// diagnostics
	output logic                              o_correction_microcontroller_err,
	output logic                              o_diagnostic_mode,
	output logic [orad_pkg::ERRC_W-1:0]       o_error_code,
	output logic [1:0]                        o_regulator_step
);
	import orad_pkg::*;

	////////////////////////////////////////////////////////////////////////////
	// start window and interface selection

	localparam int unsigned SW_W = $clog2(START_CYC + 1);

	orad_link_t      link_q, link_d;
	logic [SW_W-1:0] sw_cnt_q, sw_cnt_d;
	logic            sw_done;

	assign sw_done = (sw_cnt_q >= SW_W'(START_CYC - 1));

	always_comb begin
		link_d   = link_q;
		sw_cnt_d = sw_cnt_q;
		case (link_q)
			ORAD_LINK_START: begin
				sw_cnt_d = sw_cnt_q + 1'b1;
				if (!i_start_window_en) begin
					link_d = ORAD_LINK_RUN;
				end else if (i_one_wire_request) begin
					link_d = ORAD_LINK_CMD;
				end else if (sw_done) begin
					link_d = ORAD_LINK_RUN;
				end
			end
			ORAD_LINK_CMD: begin
				if (i_mode_set_command) begin
					link_d = ORAD_LINK_RUN;
				end
			end
			default: begin
				link_d = ORAD_LINK_RUN;
			end
		endcase
	end

	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			link_q   <= ORAD_LINK_START;
			sw_cnt_q <= '0;
		end else begin
			link_q   <= link_d;
			sw_cnt_q <= sw_cnt_d;
		end
	end

	logic run, spi_mode, i2c_mode;
	assign run      = (link_q == ORAD_LINK_RUN);
	assign spi_mode = run && i_spi_select;
	assign i2c_mode = run && !i_spi_select;

	assign o_start_window    = (link_q == ORAD_LINK_START);
	assign o_command_mode    = (link_q == ORAD_LINK_CMD);
	assign o_one_wire_active = !run;
	assign o_i2c_active      = i2c_mode;
	assign o_spi_active      = spi_mode;

	////////////////////////////////////////////////////////////////////////////
	// configuration decode

	orad_pin_t main_use, aux_a_use, aux_b_use;
	logic      cfg_ok;
	logic      aux_a_uses_alarm;

	always_comb begin
		main_use  = ORAD_PIN_NONE;
		aux_a_use = ORAD_PIN_NONE;
		aux_b_use = ORAD_PIN_NONE;
		aux_a_uses_alarm = 1'b0;
		cfg_ok = (i_pin_config >= CFG_FIRST) && (i_pin_config <= CFG_LAST) &&
			((i_pin_config > CFG_LAST_I2C) == i_spi_select);
		if (cfg_ok && !i_spi_select) begin
			// i2c: six rows per main pin use, aux combos repeat
			case ((i_pin_config - 5'h01) / 5'h06)
				5'h00:   main_use = ORAD_PIN_NONE;
				5'h01:   main_use = ORAD_PIN_ANALOG;
				default: main_use = ORAD_PIN_PULSE;
			endcase
			case ((i_pin_config - 5'h01) % 5'h06)
				5'h01: aux_a_use = ORAD_PIN_ALARM;
				5'h02: aux_b_use = ORAD_PIN_ALARM;
				5'h03: begin
					aux_a_use = ORAD_PIN_ALARM;
					aux_b_use = ORAD_PIN_ALARM;
				end
				5'h04: aux_a_use = ORAD_PIN_PULSE;
				5'h05: begin
					aux_a_use = ORAD_PIN_PULSE;
					aux_b_use = ORAD_PIN_ALARM;
				end
				default: aux_a_use = ORAD_PIN_NONE;
			endcase
		end else if (cfg_ok) begin
			// spi: three rows per main pin use
			case ((i_pin_config - 5'h13) / 5'h03)
				5'h00:   main_use = ORAD_PIN_NONE;
				5'h01:   main_use = ORAD_PIN_ANALOG;
				default: main_use = ORAD_PIN_PULSE;
			endcase
			case ((i_pin_config - 5'h13) % 5'h03)
				5'h01:   aux_a_use = ORAD_PIN_ALARM;
				5'h02:   aux_a_use = ORAD_PIN_PULSE;
				default: aux_a_use = ORAD_PIN_NONE;
			endcase
		end
		aux_a_uses_alarm = (aux_a_use == ORAD_PIN_ALARM);
	end

	////////////////////////////////////////////////////////////////////////////
	// result routing, DAC and pulse paths

	function automatic logic [RES_W-1:0] pick(input logic [1:0] s,
		input logic [RES_W-1:0] b, input logic [RES_W-1:0] t1,
		input logic [RES_W-1:0] t2);
		if (s == SRC_TEMP1) begin
			pick = t1;
		end else if (s == SRC_TEMP2) begin
			pick = t2;
		end else begin
			pick = b;
		end
	endfunction : pick

	logic [RES_W-1:0] dac_val, main_pw_val, aux_pw_val;
	assign dac_val     = pick(i_dac_source, i_result_bridge, i_result_temp1, i_result_temp2);
	assign main_pw_val = pick(i_main_pulse_source, i_result_bridge, i_result_temp1,
		i_result_temp2);
	assign aux_pw_val  = pick(i_aux_pulse_source, i_result_bridge, i_result_temp1,
		i_result_temp2);

	logic main_pulse, aux_pulse;
	logic main_pulse_en, aux_pulse_en;
	logic spi_cmd;
	assign spi_cmd       = spi_mode && i_spi_command_active;
	assign main_pulse_en = run && (main_use == ORAD_PIN_PULSE) && !spi_cmd;
	assign aux_pulse_en  = run && (aux_a_use == ORAD_PIN_PULSE) && !spi_cmd;

	orad_pulse u_main_pulse (
		.i_clk        (i_clk),
		.i_reset_n    (i_reset_n),
		.i_resolution (i_pulse_resolution),
		.i_divider    (i_pulse_divider),
		.i_enable     (main_pulse_en),
		.i_value      (main_pw_val),
		.o_pulse      (main_pulse)
	);

	orad_pulse u_aux_pulse (
		.i_clk        (i_clk),
		.i_reset_n    (i_reset_n),
		.i_resolution (i_pulse_resolution),
		.i_divider    (i_pulse_divider),
		.i_enable     (aux_pulse_en),
		.i_value      (aux_pw_val),
		.o_pulse      (aux_pulse)
	);

	////////////////////////////////////////////////////////////////////////////
	// alarm channels, both fed from the bridge result

	logic [1:0] flag;
	for (genvar g = 0; g < 2; g++) begin : g_alarm
		orad_alarm u_alarm (
			.i_clk         (i_clk),
			.i_reset_n     (i_reset_n),
			.i_threshold   (i_alarm_threshold[g]),
			.i_hysteresis  (i_alarm_hysteresis[g]),
			.i_invert      (i_alarm_invert[g]),
			.i_window      (i_alarm_window[g]),
			.i_on_delay    (i_alarm_on_delay[g]),
			.i_off_delay   (i_alarm_off_delay[g]),
			.i_value       (i_result_bridge),
			.i_value_valid (i_result_valid),
			.o_alarm       (flag[g])
		);
	end

	////////////////////////////////////////////////////////////////////////////
	// supervision and diagnostics

	logic [WDG_W-1:0] wdg_cpu_q, wdg_cpu_d, wdg_loop_q, wdg_loop_d;
	logic             err_q, err_d, err_hi_q, err_hi_d, perr_q, perr_d;
	logic [ERRC_W-1:0] code_q, code_d;
	logic [ERRC_W-1:0] new_code;

	always_comb begin
		wdg_cpu_d  = i_controller_alive ? '0 : wdg_cpu_q + 1'b1;
		wdg_loop_d = i_loop_progress ? '0 : wdg_loop_q + 1'b1;
		if (wdg_cpu_q == WDG_W'(WDG_LIMIT)) begin
			wdg_cpu_d = wdg_cpu_q;
		end
		if (wdg_loop_q == WDG_W'(WDG_LIMIT)) begin
			wdg_loop_d = wdg_loop_q;
		end
		new_code = ERR_NONE;
		if (i_signature_check_done && !i_signature_match) begin
			new_code = ERR_SIGNATURE;
		end else if (i_parity_error) begin
			new_code = ERR_PARITY;
		end else if (i_memory_error) begin
			new_code = ERR_MEMORY;
		end else if (wdg_cpu_q == WDG_W'(WDG_LIMIT) || wdg_loop_q == WDG_W'(WDG_LIMIT)) begin
			new_code = ERR_WATCHDOG;
		end else if (i_inp_range_low || i_inp_range_high) begin
			new_code = ERR_WIRE;
		end
		perr_d   = perr_q | i_parity_error;
		err_d    = err_q;
		err_hi_d = err_hi_q;
		code_d   = code_q;
		if (!err_q && new_code != ERR_NONE) begin
			err_d    = 1'b1;
			err_hi_d = i_error_high_level;
			code_d   = new_code;
		end
	end

	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			wdg_cpu_q  <= '0;
			wdg_loop_q <= '0;
			err_q      <= 1'b0;
			err_hi_q   <= 1'b0;
			perr_q     <= 1'b0;
			code_q     <= ERR_NONE;
		end else begin
			wdg_cpu_q  <= wdg_cpu_d;
			wdg_loop_q <= wdg_loop_d;
			err_q      <= err_d;
			err_hi_q   <= err_hi_d;
			perr_q     <= perr_d;
			code_q     <= code_d;
		end
	end

	assign o_correction_microcontroller_err = perr_q;
	assign o_diagnostic_mode = err_q;
	assign o_error_code      = code_q;

	////////////////////////////////////////////////////////////////////////////
	// pin drivers

	logic [DAC_W-1:0] dac_d, dac_q;
	always_comb begin
		dac_d = dac_val[RES_W-1 -: DAC_W];
		if (err_q) begin
			dac_d = err_hi_q ? DAC_MAX : DAC_MIN;
		end
	end
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			dac_q <= '0;
		end else begin
			dac_q <= dac_d;
		end
	end
	assign o_dac_code = dac_q;

	// main pin: analog stays under error to show the diagnostic level
	assign o_main_analog_en  = run && (main_use == ORAD_PIN_ANALOG);
	assign o_main_pin_driver = main_pulse && !err_q;
	assign o_main_pin_oe     = run && (main_use == ORAD_PIN_PULSE);

	logic nom_a;
	assign nom_a = spi_mode && !i_spi_command_active && (aux_a_use != ORAD_PIN_NONE);

	always_comb begin
		o_aux_pin_a    = 1'b0;
		o_aux_pin_a_oe = 1'b0;
		if (spi_mode && !nom_a) begin
			o_aux_pin_a    = i_spi_sdo;
			o_aux_pin_a_oe = i_spi_sdo_en;
		end else if (run && aux_a_use == ORAD_PIN_ALARM) begin
			o_aux_pin_a    = flag[0] && !err_q;
			o_aux_pin_a_oe = 1'b1;
		end else if (run && aux_a_use == ORAD_PIN_PULSE) begin
			o_aux_pin_a    = aux_pulse && !err_q;
			o_aux_pin_a_oe = 1'b1;
		end
	end

	assign o_aux_pin_b    = flag[1] && !err_q;
	assign o_aux_pin_b_oe = i2c_mode && (aux_b_use == ORAD_PIN_ALARM);
	assign o_aux_pin_b_select_in = spi_mode && !nom_a;
	assign o_sda_data_in  = spi_mode && !nom_a;

	assign o_threshold_flag_a = flag[0] && aux_a_uses_alarm;
	assign o_threshold_flag_b = flag[1] && !spi_mode;

	assign o_regulator_step = i_regulator_setting;

	////////////////////////////////////////////////////////////////////////////
	// checks

	chk_window_len: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		(link_q == ORAD_LINK_START) && i_start_window_en && !i_one_wire_request && sw_done
		|=> run) else $error("start window did not end on time");
	chk_cmd_hold: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		o_command_mode && !i_mode_set_command |=> o_command_mode)
		else $error("command mode left without command");
	chk_skip_window: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		o_start_window && !i_start_window_en |=> run)
		else $error("disabled window not skipped");
	chk_spi_no_flag_b: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		spi_mode |-> !o_aux_pin_b_oe && !o_threshold_flag_b)
		else $error("flag b driven in spi mode");
	chk_spi_pulse_stop: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		spi_cmd ##1 spi_cmd |-> !main_pulse)
		else $error("main pulse ran during spi command");
	chk_diag_level: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		$rose(err_q) |=> o_dac_code == (err_hi_q ? DAC_MAX : DAC_MIN))
		else $error("diagnostic level not forced");
	chk_parity_flag: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		i_parity_error |=> perr_q && err_q)
		else $error("parity error not flagged");
	chk_wire_err: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		(i_inp_range_low || i_inp_range_high) |=> err_q)
		else $error("broken wire not flagged");
	chk_sig_err: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		i_signature_check_done && !i_signature_match |=> err_q)
		else $error("signature mismatch not flagged");
	chk_bad_cfg: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		!cfg_ok |-> !o_main_pin_oe && !o_aux_pin_b_oe && !o_main_analog_en)
		else $error("invalid configuration drove a pin");

endmodule : orad_top

// [rtl/orad_pkg.sv]
// package with constants and types for the output routing and diagnostics block
package orad_pkg;

	localparam int unsigned CLK_HZ           = 250_000_000;
	localparam int unsigned START_WINDOW_MS  = 20;
	localparam int unsigned START_WINDOW_CYC = START_WINDOW_MS * (CLK_HZ / 1000);

	localparam int unsigned RES_W    = 15;
	localparam int unsigned DAC_W    = 11;
	localparam int unsigned PWM_W    = 12;
	localparam int unsigned PWM_RES_MIN = 9;
	localparam int unsigned DIV_W    = 8;
	localparam int unsigned DLY_W    = 8;
	localparam int unsigned CFG_W    = 5;
	localparam int unsigned WDG_W    = 16;
	localparam int unsigned WDG_LIMIT_DEF = 1000;
	localparam int unsigned ERRC_W   = 8;

	// output configuration range: 1..18 two-wire style, 19..27 four-wire style
	localparam logic [CFG_W-1:0] CFG_FIRST    = 5'h01;
	localparam logic [CFG_W-1:0] CFG_LAST_I2C = 5'h12;
	localparam logic [CFG_W-1:0] CFG_LAST     = 5'h1b;

	// result source selection
	localparam logic [1:0] SRC_BRIDGE = 2'h0;
	localparam logic [1:0] SRC_TEMP1  = 2'h1;
	localparam logic [1:0] SRC_TEMP2  = 2'h2;

	// diagnostic error codes for the serial output registers
	localparam logic [ERRC_W-1:0] ERR_NONE      = 8'h00;
	localparam logic [ERRC_W-1:0] ERR_SIGNATURE = 8'h01;
	localparam logic [ERRC_W-1:0] ERR_PARITY    = 8'h02;
	localparam logic [ERRC_W-1:0] ERR_WATCHDOG  = 8'h03;
	localparam logic [ERRC_W-1:0] ERR_WIRE      = 8'h04;
	localparam logic [ERRC_W-1:0] ERR_MEMORY    = 8'h05;

	localparam logic [DAC_W-1:0] DAC_MAX = 11'h7ff;
	localparam logic [DAC_W-1:0] DAC_MIN = 11'h000;

	typedef enum logic [1:0] {
		ORAD_LINK_START,
		ORAD_LINK_CMD,
		ORAD_LINK_RUN
	} orad_link_t;

	typedef enum logic [1:0] {
		ORAD_PIN_NONE,
		ORAD_PIN_ANALOG,
		ORAD_PIN_PULSE,
		ORAD_PIN_ALARM
	} orad_pin_t;

endpackage : orad_pkg

// [rtl/orad_alarm.sv]
// one threshold alarm channel with hysteresis, direction, delays and window mode
`timescale 1ns/1ps
module orad_alarm
	import orad_pkg::*;
(
	// clock and reset
	input  wire logic                 i_clk,
	input  wire logic                 i_reset_n,
	// settings
	input  wire logic [RES_W-1:0]     i_threshold,
	input  wire logic [RES_W-1:0]     i_hysteresis,
	input  wire logic                 i_invert,
	input  wire logic                 i_window,
	input  wire logic [DLY_W-1:0]     i_on_delay,
	input  wire logic [DLY_W-1:0]     i_off_delay,
	// sample
	input  wire logic [RES_W-1:0]     i_value,
	input  wire logic                 i_value_valid,
	// result
	output logic                      o_alarm
);
	import orad_pkg::*;

	logic             raw;
	logic             state_q, state_d;
	logic [DLY_W-1:0] cnt_q, cnt_d;
	logic [RES_W:0]   hi_lim, lo_lim;

	always_comb begin
		hi_lim = {1'b0, i_threshold} + {1'b0, i_hysteresis};
		lo_lim = ({1'b0, i_threshold} > {1'b0, i_hysteresis}) ?
			{1'b0, i_threshold} - {1'b0, i_hysteresis} : '0;
		if (i_window) begin
			// window: active while the value lies inside lo..hi
			raw = ({1'b0, i_value} >= lo_lim) && ({1'b0, i_value} <= hi_lim);
		end else if (state_q ^ i_invert) begin
			raw = ({1'b0, i_value} >= lo_lim);
		end else begin
			raw = ({1'b0, i_value} > hi_lim);
		end
		raw = raw ^ (i_invert & ~i_window);
	end

	always_comb begin
		state_d = state_q;
		cnt_d   = cnt_q;
		if (i_value_valid) begin
			if (raw == state_q) begin
				cnt_d = '0;
			end else if (cnt_q >= (state_q ? i_off_delay : i_on_delay)) begin
				state_d = raw;
				cnt_d   = '0;
			end else begin
				cnt_d = cnt_q + 1'b1;
			end
		end
	end

	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			state_q <= 1'b0;
			cnt_q   <= '0;
		end else begin
			state_q <= state_d;
			cnt_q   <= cnt_d;
		end
	end

	assign o_alarm = state_q;

endmodule : orad_alarm

// [rtl/orad_pulse.sv]
// pulse-width generator with resolution and clock divider settings
`timescale 1ns/1ps
module orad_pulse
	import orad_pkg::*;
(
	// clock and reset
	input  wire logic                 i_clk,
	input  wire logic                 i_reset_n,
	// settings
	input  wire logic [3:0]           i_resolution,
	input  wire logic [DIV_W-1:0]     i_divider,
	input  wire logic                 i_enable,
	// duty value
	input  wire logic [RES_W-1:0]     i_value,
	// output
	output logic                      o_pulse
);
	import orad_pkg::*;

	logic [3:0]       res;
	logic [PWM_W-1:0] duty;
	logic [PWM_W-1:0] top;
	logic [PWM_W-1:0] cnt_q, cnt_d;
	logic [DIV_W-1:0] div_q, div_d;
	logic             out_q, out_d;

	always_comb begin
		res = i_resolution;
		if (res > 4'(PWM_W)) begin
			res = 4'(PWM_W);
		end
		if (res < 4'(PWM_RES_MIN)) begin
			res = 4'(PWM_RES_MIN);
		end
		// duty taken from the top bits of the routed result
		duty = PWM_W'(i_value >> (RES_W - 32'(res)));
		top  = PWM_W'((32'h1 << res) - 1);
	end

	always_comb begin
		div_d = div_q;
		cnt_d = cnt_q;
		out_d = 1'b0;
		if (i_enable) begin
			out_d = (cnt_q < duty);
			if (div_q >= i_divider) begin
				div_d = '0;
				cnt_d = (cnt_q >= top) ? '0 : cnt_q + 1'b1;
			end else begin
				div_d = div_q + 1'b1;
			end
		end else begin
			div_d = '0;
			cnt_d = '0;
		end
	end

	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			div_q <= '0;
			cnt_q <= '0;
			out_q <= 1'b0;
		end else begin
			div_q <= div_d;
			cnt_q <= cnt_d;
			out_q <= out_d;
		end
	end

	assign o_pulse = out_q;

endmodule : orad_pulse

// [testbench/orad_host_model.sv]
// serial host model that issues one-wire requests, mode-set commands and spi traffic
`timescale 1ns/1ps
module orad_host_model (
	// clock and reset
	input  wire logic i_clk,
	input  wire logic i_reset_n,
	// bench orders
	input  wire logic i_req_go,
	input  wire logic i_set_go,
	input  wire logic i_spi_go,
	// to the device
	output logic      o_request,
	output logic      o_mode_set,
	output logic      o_spi_cmd
);
	// each order is registered and appears on the next edge for as long as it is held
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_request  <= 1'b0;
			o_mode_set <= 1'b0;
			o_spi_cmd  <= 1'b0;
		end else begin
			o_request  <= i_req_go;
			o_mode_set <= i_set_go;
			o_spi_cmd  <= i_spi_go;
		end
	end
endmodule : orad_host_model

// [testbench/testbench.sv]
// testbench for the output routing and diagnostics block
`timescale 1ns/1ps
`define CHK(n, e, a) begin compares++; if ((a) !== (e)) begin error_cnt++; \
	$display("wrong value %s exp %h got %h", n, e, a); end end
module testbench;
	import orad_pkg::*;
	localparam int unsigned SC = 50;
	logic i_clk = 1'b0, i_reset_n = 1'b0, win = 1'b1, spi = 1'b0, kick = 1'b0, kick_en = 1'b1;
	logic [CFG_W-1:0] cfg = 5'h07;
	logic [RES_W-1:0] thr [2] = '{15'h4000, 15'h2000}, hys [2] = '{15'h0010, 15'h0010};
	logic [DLY_W-1:0] dly [2] = '{8'h00, 8'h00};
	logic par = 1'b0, mem = 1'b0, rq = 1'b0, st = 1'b0, sp = 1'b0, w_rq, w_st, w_sp;
	logic st_win, cmd, ow, i2c, spia, boe, bsel, sdain, diag, merr;
	logic [DAC_W-1:0] dac;
	logic [ERRC_W-1:0] code;
	logic [1:0] dsrc = 2'h0, reg_set = 2'h2, rstep;
	logic [RES_W-1:0] bridge = 15'h7f00, t1 = 15'h1234, t2 = 15'h0abc;
	logic sig_done = 1'b0, sig_ok = 1'b1, rlow = 1'b0, rhi = 1'b0, ehi = 1'b1;
	logic fa, fb, pa, pb, aoe, aen, moe, mdrv;
	int error_cnt = 0, compares = 0, n;
	initial forever #2 i_clk = ~i_clk;
	always @(posedge i_clk) kick <= kick_en & ~kick;
	orad_host_model host_u (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_req_go(rq), .i_set_go(st),
		.i_spi_go(sp), .o_request(w_rq), .o_mode_set(w_st), .o_spi_cmd(w_sp));
	orad_top #(.START_CYC(SC), .WDG_LIMIT(20)) dut_u (.i_clk(i_clk), .i_reset_n(i_reset_n),
		.i_start_window_en(win), .i_spi_select(spi), .i_pin_config(cfg), .i_dac_source(dsrc),
		.i_main_pulse_source(2'h1), .i_aux_pulse_source(dsrc), .i_pulse_resolution(4'h9),
		.i_pulse_divider(8'h01), .i_regulator_setting(reg_set), .i_alarm_threshold(thr),
		.i_alarm_hysteresis(hys), .i_alarm_invert(2'h0), .i_alarm_window(2'h0),
		.i_alarm_on_delay(dly), .i_alarm_off_delay(dly), .i_result_bridge(bridge),
		.i_result_temp1(t1), .i_result_temp2(t2), .i_result_valid(kick),
		.i_one_wire_request(w_rq), .i_mode_set_command(w_st), .i_spi_command_active(w_sp),
		.i_spi_sdo(kick), .i_spi_sdo_en(w_sp), .i_signature_check_done(sig_done),
		.i_signature_match(sig_ok), .i_parity_error(par), .i_memory_error(mem),
		.i_controller_alive(kick), .i_loop_progress(kick), .i_inp_range_low(rlow),
		.i_inp_range_high(rhi), .i_error_high_level(ehi), .o_start_window(st_win),
		.o_command_mode(cmd), .o_one_wire_active(ow), .o_i2c_active(i2c), .o_spi_active(spia),
		.o_main_pin_driver(mdrv), .o_main_pin_oe(moe), .o_main_analog_en(aen), .o_dac_code(dac),
		.o_aux_pin_a(pa), .o_aux_pin_a_oe(aoe), .o_aux_pin_b(pb), .o_aux_pin_b_oe(boe),
		.o_aux_pin_b_select_in(bsel), .o_sda_data_in(sdain), .o_threshold_flag_a(fa),
		.o_threshold_flag_b(fb), .o_correction_microcontroller_err(merr), .o_diagnostic_mode(diag),
		.o_error_code(code), .o_regulator_step(rstep));
	task automatic stop_test();
		if (error_cnt == 0 && compares > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : stop_test
	task automatic rst(input logic w, input logic s, input logic [CFG_W-1:0] c);
		i_reset_n <= 1'b0; win <= w; spi <= s; cfg <= c; kick_en <= 1'b1;
		repeat (2) @(posedge i_clk);
		i_reset_n <= 1'b1;
	endtask : rst
	task automatic t_window();
		rst(1'b1, 1'b0, 5'h07);
		n = 0;
		do begin @(posedge i_clk); #1; n++; end while (!i2c && n < 200);
		`CHK("run edge", SC, n)
		if (!i2c) stop_test();
		`CHK("i2c", 1'b1, i2c)
		`CHK("window", 1'b0, st_win)
	endtask : t_window
	task automatic t_request();
		rst(1'b1, 1'b0, 5'h07);
		@(posedge i_clk); #1;
		`CHK("one wire", 1'b1, ow)
		@(posedge i_clk); rq <= 1'b1; @(posedge i_clk); rq <= 1'b0;
		repeat (SC + 10) @(posedge i_clk); #1;
		`CHK("cmd hold", 1'b1, cmd)
		`CHK("no i2c", 1'b0, i2c)
		@(posedge i_clk); st <= 1'b1; @(posedge i_clk); st <= 1'b0;
		repeat (3) @(posedge i_clk); #1;
		`CHK("cmd left", 1'b0, cmd)
	endtask : t_request
	task automatic t_spi();
		rst(1'b0, 1'b1, 5'h13);
		repeat (3) @(posedge i_clk); #1;
		`CHK("spi", 1'b1, spia)
		`CHK("b oe", 1'b0, boe)
		`CHK("b sel", 1'b1, bsel)
		`CHK("sda in", 1'b1, sdain)
		rst(1'b0, 1'b1, 5'h1a);
		repeat (4) @(posedge i_clk); #1;
		`CHK("a alarm", 2'h3, {pa, aoe})
		`CHK("nom sel", 1'b0, bsel)
		`CHK("pulse on", 2'h3, {mdrv, moe})
		@(posedge i_clk);
		sp <= 1'b1;
		repeat (4) @(posedge i_clk); #1;
		`CHK("cm sel", 1'b1, bsel)
		`CHK("cm sdo en", 1'b1, aoe)
		`CHK("pulse cut", 1'b0, mdrv)
		@(posedge i_clk);
		sp <= 1'b0;
	endtask : t_spi
	task automatic t_route();
		rst(1'b0, 1'b0, 5'h0a);
		reg_set <= 2'h3;
		repeat (6) @(posedge i_clk); #1;
		`CHK("dac bridge", 11'h7f0, dac)
		`CHK("flags", 4'hf, {fa, fb, pa, pb})
		`CHK("oes", 4'he, {aoe, boe, aen, moe})
		`CHK("reg step", 2'h3, rstep)
		@(posedge i_clk);
		dsrc <= 2'h1;
		bridge <= 15'h1000;
		t1 <= 15'h6000;
		repeat (6) @(posedge i_clk); #1;
		`CHK("dac temp1", 11'h600, dac)
		`CHK("flags temp", 2'h0, {fa, fb})
		@(posedge i_clk);
		dsrc <= 2'h2;
		cfg <= 5'h1c;
		repeat (2) @(posedge i_clk); #1;
		`CHK("dac temp2", 11'h0ab, dac)
		`CHK("bad cfg", 3'h0, {aoe, boe, aen})
	endtask : t_route
	task automatic t_error(input int k, input logic [ERRC_W-1:0] e, input logic hi);
		rst(1'b0, 1'b0, 5'h07);
		repeat (3) @(posedge i_clk);
		par <= (k == 1);
		kick_en <= (k != 0);
		sig_done <= (k == 2);
		sig_ok <= (k != 2);
		rlow <= (k == 3);
		rhi <= (k == 4);
		ehi <= hi;
		@(posedge i_clk);
		par <= 1'b0;
		sig_done <= 1'b0;
		sig_ok <= 1'b1;
		rlow <= 1'b0;
		rhi <= 1'b0;
		repeat (25) @(posedge i_clk); mem <= 1'b1; @(posedge i_clk); mem <= 1'b0;
		repeat (3) @(posedge i_clk); #1;
		`CHK("diag", 1'b1, diag)
		`CHK("code", e, code)
		`CHK("dac", hi ? DAC_MAX : DAC_MIN, dac)
		`CHK("cmc err", k == 1, merr)
		`CHK("analog on", 2'h2, {aen, mdrv})
	endtask : t_error
	initial begin
		t_window();
		t_request();
		t_spi();
		t_route();
		t_error(1, ERR_PARITY, 1'b1);
		t_error(0, ERR_WATCHDOG, 1'b1);
		t_error(2, ERR_SIGNATURE, 1'b0);
		t_error(3, ERR_WIRE, 1'b0);
		t_error(4, ERR_WIRE, 1'b1);
		stop_test();
	end
endmodule : testbench
